// ### design/pbc_pkg.sv
// Purpose: shared constants for the power budget capability register bank
// Assumes: byte offsets within a 4 KB configuration window, word access only
// Notes:   values here are used by both design modules and the bench
package pbc_pkg;

  localparam int          PBC_AW           = 12;
  localparam int          PBC_DW           = 32;
  localparam int          PBC_NUM_VALUES   = 8;
  localparam int          PBC_IDX_W        = 3;

  // register byte offsets
  localparam logic [11:0] PBC_OFF_HDR      = 12'h0280;
  localparam logic [11:0] PBC_OFF_SEL      = 12'h0284;
  localparam logic [11:0] PBC_OFF_WINDOW   = 12'h0288;
  localparam logic [11:0] PBC_OFF_SYSALLOC = 12'h028C;
  localparam logic [11:0] PBC_OFF_VAL_BASE = 12'h0300;
  localparam logic [11:0] PBC_OFF_VAL_LAST = 12'h031C;
  localparam logic [11:0] PBC_OFF_SW_CTRL  = 12'h0404;

  // capability header fields
  localparam int          PBC_IDENT_LSB    = 0;
  localparam int          PBC_IDENT_W      = 16;
  localparam int          PBC_VERS_LSB     = 16;
  localparam int          PBC_VERS_W       = 4;
  localparam int          PBC_NEXT_LSB     = 20;
  localparam int          PBC_NEXT_W       = 12;

  // select, system allocated, switch control fields
  localparam int          PBC_SEL_W        = 8;
  localparam int          PBC_ALLOC_BIT    = 0;
  localparam int          PBC_REG_UNL_BIT  = 0;
  localparam int          PBC_VAL_UNL_BIT  = 1;

  // reset values
  localparam logic [15:0] PBC_IDENT_RST    = 16'h0000;
  localparam logic [3:0]  PBC_VERS_RST     = 4'h0;
  localparam logic [11:0] PBC_NEXT_RST     = 12'h000;
  localparam logic [7:0]  PBC_SEL_RST      = 8'h00;
  localparam logic [31:0] PBC_VAL_RST      = 32'h0000_0000;
  localparam logic [31:0] PBC_ZERO         = 32'h0000_0000;

  // bus answer
  localparam logic        PBC_RESP_OKAY    = 1'b0;

  typedef enum logic [0:0] {
    PBC_ST_IDLE = 1'b0,
    PBC_ST_RD   = 1'b1
  } pbc_bus_e;

endpackage : pbc_pkg

// ### design/pbc_val_if.sv
// Purpose: carrier between the bus logic and the data value store
// Assumes: single clock, store reads are combinational
// Notes:   ctrl side drives writes and selects, store side answers
`timescale 1ns/1ps
interface pbc_val_if;
  logic        wr_en;
  logic [2:0]  wr_idx;
  logic [31:0] wr_data;
  logic        unlock;
  logic [7:0]  sel;
  logic [31:0] win_data;
  logic [2:0]  raw_idx;
  logic [31:0] raw_data;

  modport ctrl  (output wr_en, wr_idx, wr_data, unlock, sel, raw_idx,
                 input  win_data, raw_data);
  modport store (input  wr_en, wr_idx, wr_data, unlock, sel, raw_idx,
                 output win_data, raw_data);
endinterface : pbc_val_if

// ### design/pbc_value_store.sv
// Purpose: eight sticky budget data values with a selectable window
// Assumes: cleared only by the fundamental reset
// Notes:   no non-fundamental reset reaches this module on purpose
`timescale 1ns/1ps
module pbc_value_store
  import pbc_pkg::*;
#(
  parameter int DEPTH = PBC_NUM_VALUES
)
(
  input  wire logic hclk,
  input  wire logic hresetn,
  pbc_val_if.store  vif
);

  logic [31:0] value_r [DEPTH];
  logic        wr_ok_w;
  logic        sel_hit_w;
  logic [31:0] cur_entry_w;

  assign wr_ok_w     = vif.wr_en & vif.unlock;
  assign sel_hit_w   = (vif.sel < 8'(DEPTH));
  assign vif.win_data = sel_hit_w ? value_r[vif.sel[2:0]]
                                  : PBC_ZERO;
  assign vif.raw_data = value_r[vif.raw_idx];
  assign cur_entry_w = value_r[vif.wr_idx];

  // fundamental reset only: the entries are sticky
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_val
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          value_r[gi] <= PBC_VAL_RST;
        else if (wr_ok_w && vif.wr_idx == 3'(gi))
          value_r[gi] <= vif.wr_data;
      end
    end
  endgenerate

  property p_unlocked_write;
    @(posedge hclk) disable iff (!hresetn)
    (vif.wr_en && vif.unlock)
      |=> value_r[$past(vif.wr_idx)] == $past(vif.wr_data);
  endproperty
  val_write_a: assert property (p_unlocked_write)
    else $error("unlocked value write not stored");

  property p_locked_discard;
    @(posedge hclk) disable iff (!hresetn)
    (vif.wr_en && !vif.unlock)
      |=> value_r[$past(vif.wr_idx)] == $past(cur_entry_w);
  endproperty
  val_locked_a: assert property (p_locked_discard)
    else $error("locked value write changed an entry");

  window_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (vif.sel > 8'h07) |-> vif.win_data == PBC_ZERO)
    else $error("window not zero for select above seven");

  window_match_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (vif.sel <= 8'h07) |-> vif.win_data == value_r[vif.sel[2:0]])
    else $error("window does not show selected entry");

endmodule : pbc_value_store

// ### design/pbc_power_budget_regs.sv
// Purpose: power budget capability registers behind an AHB-Lite slave
// Assumes: word transfers only, single master, hot_reset_n synchronous
// Notes:   reads take one wait state, writes none, response always OKAY
`timescale 1ns/1ps

module pbc_power_budget_regs
  import pbc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hot_reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             system_allocated_flag,
  output logic             budget_value_unlock
);

  pbc_val_if vif ();

  pbc_bus_e    st_r;
  pbc_bus_e    st_nxt;
  logic [11:0] addr_q_r;
  logic        wr_pend_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  logic        hresp_r;

  logic [15:0] capability_identifier_r;
  logic [3:0]  capability_version_field_r;
  logic [11:0] next_capability_pointer_r;
  logic [7:0]  data_value_selector_r;
  logic        system_allocated_flag_r;
  logic        reg_unlock_r;
  logic        budget_value_unlock_r;

  logic        addr_ph_w;
  logic        rd_start_w;
  logic        wr_hdr_w;
  logic        wr_sel_w;
  logic        wr_alloc_w;
  logic        wr_ctrl_w;
  logic        val_hit_w;
  logic [31:0] hdr_w;
  logic [31:0] sw_ctrl_w;
  logic [31:0] rdata_w;
  logic [15:0] hdr_ident_w;
  logic [3:0]  hdr_version_w;
  logic [11:0] hdr_next_w;

  // hsize is not decoded: only whole words are ever issued
  assign addr_ph_w  = hsel & htrans[1] & hready;
  assign rd_start_w = addr_ph_w & ~hwrite;
  assign st_nxt     = rd_start_w ? PBC_ST_RD : PBC_ST_IDLE;

  // writes complete in the data phase that follows the address phase
  assign wr_hdr_w   = wr_pend_r & (addr_q_r == PBC_OFF_HDR) & reg_unlock_r;
  assign wr_sel_w   = wr_pend_r & (addr_q_r == PBC_OFF_SEL);
  assign wr_alloc_w = wr_pend_r & (addr_q_r == PBC_OFF_SYSALLOC)
                      & reg_unlock_r;
  assign wr_ctrl_w  = wr_pend_r & (addr_q_r == PBC_OFF_SW_CTRL);
  assign val_hit_w  = (addr_q_r >= PBC_OFF_VAL_BASE)
                      & (addr_q_r <= PBC_OFF_VAL_LAST);

  assign vif.wr_en   = wr_pend_r & val_hit_w;
  assign vif.wr_idx  = addr_q_r[4:2];
  assign vif.wr_data = hwdata;
  assign vif.unlock  = budget_value_unlock_r;
  assign vif.sel     = data_value_selector_r;
  assign vif.raw_idx = addr_q_r[4:2];

  assign hdr_w   = {next_capability_pointer_r,
                    capability_version_field_r,
                    capability_identifier_r};
  assign sw_ctrl_w = {30'h0000_0000, budget_value_unlock_r, reg_unlock_r};

  // header fields as written; only taken while the register unlock is set
  assign hdr_ident_w   = hwdata[PBC_IDENT_LSB +: PBC_IDENT_W];
  assign hdr_version_w = hwdata[PBC_VERS_LSB +: PBC_VERS_W];
  assign hdr_next_w    = hwdata[PBC_NEXT_LSB +: PBC_NEXT_W];

  // unmapped offsets and reserved bits read as zero
  assign rdata_w =
    (addr_q_r == PBC_OFF_HDR)      ? hdr_w :
    (addr_q_r == PBC_OFF_SEL)      ? {24'h00_0000, data_value_selector_r} :
    (addr_q_r == PBC_OFF_WINDOW)   ? vif.win_data :
    (addr_q_r == PBC_OFF_SYSALLOC) ? {31'h0000_0000,
                                      system_allocated_flag_r} :
    val_hit_w                      ? vif.raw_data :
    (addr_q_r == PBC_OFF_SW_CTRL)  ? sw_ctrl_w :
                                     PBC_ZERO;

  pbc_value_store #(
    .DEPTH   (PBC_NUM_VALUES)
  ) u_store (
    .hclk    (hclk),
    .hresetn (hresetn),
    .vif     (vif.store)
  );

  // bus pipeline: a read waits one cycle so that a write just ahead of it
  // has landed before the read data is captured
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r        <= PBC_ST_IDLE;
      addr_q_r    <= 12'h000;
      wr_pend_r   <= 1'b0;
      hreadyout_r <= 1'b1;
      hresp_r     <= PBC_RESP_OKAY;
    end
    else
    begin
      st_r        <= st_nxt;
      wr_pend_r   <= addr_ph_w & hwrite;
      hreadyout_r <= ~rd_start_w;
      hresp_r     <= PBC_RESP_OKAY;
      if (addr_ph_w)
        addr_q_r <= haddr[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= PBC_ZERO;
    else if (st_r == PBC_ST_RD)
      hrdata_r <= rdata_w;
  end

  // capability header, lock-protected by the register unlock bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      capability_identifier_r    <= PBC_IDENT_RST;
      capability_version_field_r <= PBC_VERS_RST;
      next_capability_pointer_r  <= PBC_NEXT_RST;
    end
    else if (!hot_reset_n)
    begin
      capability_identifier_r    <= PBC_IDENT_RST;
      capability_version_field_r <= PBC_VERS_RST;
      next_capability_pointer_r  <= PBC_NEXT_RST;
    end
    else if (wr_hdr_w)
    begin
      capability_identifier_r    <= hdr_ident_w;
      capability_version_field_r <= hdr_version_w;
      next_capability_pointer_r  <= hdr_next_w;
    end
  end

  // selector, system allocated flag and switch control bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_value_selector_r   <= PBC_SEL_RST;
      system_allocated_flag_r <= 1'b0;
      reg_unlock_r            <= 1'b0;
      budget_value_unlock_r   <= 1'b0;
    end
    else if (!hot_reset_n)
    begin
      data_value_selector_r   <= PBC_SEL_RST;
      system_allocated_flag_r <= 1'b0;
      reg_unlock_r            <= 1'b0;
      budget_value_unlock_r   <= 1'b0;
    end
    else
    begin
      if (wr_sel_w)
        data_value_selector_r <= hwdata[PBC_SEL_W-1:0];
      if (wr_alloc_w)
        system_allocated_flag_r <= hwdata[PBC_ALLOC_BIT];
      if (wr_ctrl_w)
      begin
        reg_unlock_r          <= hwdata[PBC_REG_UNL_BIT];
        budget_value_unlock_r <= hwdata[PBC_VAL_UNL_BIT];
      end
    end
  end

  assign hrdata                = hrdata_r;
  assign hreadyout             = hreadyout_r;
  assign hresp                 = hresp_r;
  assign system_allocated_flag = system_allocated_flag_r;
  assign budget_value_unlock   = budget_value_unlock_r;

  // a read: one stalled cycle, then ready with the data
  sequence s_rd_addr;
    rd_start_w;
  endsequence

  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_rd_timing;
    @(posedge hclk) disable iff (!hresetn)
    s_rd_addr |=> s_rd_answer;
  endproperty
  rd_timing_a: assert property (p_rd_timing)
    else $error("read answer not one wait state");

  property p_window_read;
    @(posedge hclk) disable iff (!hresetn)
    (rd_start_w && haddr[11:0] == PBC_OFF_WINDOW && hot_reset_n)
      ##1 hot_reset_n |=> hrdata == $past(vif.win_data);
  endproperty
  window_read_a: assert property (p_window_read)
    else $error("window read returned wrong data");

  property p_hdr_write;
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && addr_q_r == PBC_OFF_HDR && reg_unlock_r && hot_reset_n)
      |=> capability_identifier_r == $past(hwdata[15:0])
          && capability_version_field_r == $past(hwdata[19:16]);
  endproperty
  hdr_write_a: assert property (p_hdr_write)
    else $error("unlocked header write not stored");

  property p_hdr_locked;
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && addr_q_r == PBC_OFF_HDR && !reg_unlock_r && hot_reset_n)
      |=> $stable(capability_version_field_r)
          && $stable(capability_identifier_r);
  endproperty
  hdr_locked_a: assert property (p_hdr_locked)
    else $error("locked header write took effect");

  alloc_flag_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && addr_q_r == PBC_OFF_SYSALLOC && hot_reset_n)
      |=> system_allocated_flag == ($past(reg_unlock_r)
          ? $past(hwdata[0]) : $past(system_allocated_flag_r)))
    else $error("system allocated flag wrong after write");

  hot_keep_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!hot_reset_n && !vif.wr_en) |=> $stable(vif.raw_data)
      || $changed(addr_q_r))
    else $error("hot reset disturbed a data value");

  // hot reset clears every register except the sticky data values
  hot_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !hot_reset_n |=> capability_identifier_r == PBC_IDENT_RST
      && capability_version_field_r == PBC_VERS_RST
      && data_value_selector_r == PBC_SEL_RST
      && !system_allocated_flag_r && !budget_value_unlock_r)
    else $error("hot reset left a register set");

  sel_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_sel_w && hot_reset_n)
      |=> data_value_selector_r == $past(hwdata[PBC_SEL_W-1:0]))
    else $error("selector write not stored");

  unlock_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_ctrl_w && hot_reset_n)
      |=> budget_value_unlock == $past(hwdata[PBC_VAL_UNL_BIT]))
    else $error("value unlock bit not stored");

  // a direct value read: address, one stalled cycle, then the answer
  sequence s_val_rd_addr;
    rd_start_w && haddr[11:0] >= PBC_OFF_VAL_BASE
      && haddr[11:0] <= PBC_OFF_VAL_LAST;
  endsequence

  property p_value_read;
    @(posedge hclk) disable iff (!hresetn)
    s_val_rd_addr ##1 1'b1 |=> hrdata == $past(vif.raw_data);
  endproperty
  value_read_a: assert property (p_value_read)
    else $error("value read returned wrong data");

  // reserved bits must read zero so software can widen fields later
  sequence s_sel_rd;
    st_r == PBC_ST_RD && addr_q_r == PBC_OFF_SEL;
  endsequence

  sel_reserved_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_sel_rd |=> hrdata[31:PBC_SEL_W] == 24'h00_0000)
    else $error("selector reserved bits not zero");

  alloc_read_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_r == PBC_ST_RD && addr_q_r == PBC_OFF_SYSALLOC)
      |=> hrdata[31:1] == 31'h0
          && hrdata[0] == $past(system_allocated_flag_r))
    else $error("allocated flag read wrong");

endmodule : pbc_power_budget_regs

// ### tb/pbc_power_budget_regs_bench.sv
// Purpose: self-checking bench for the power budget capability registers
// Assumes: one AHB-Lite master, word transfers, slave ready fed back
// Notes:   data values reading zero after reset is a design choice
`timescale 1ns/1ps
module pbc_power_budget_regs_bench
  import pbc_pkg::*;
();
  logic        hclk;
  logic        hresetn;
  logic        hot_reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        system_allocated_flag;
  logic        budget_value_unlock;
  logic [31:0] rdat;
  int          fails;
  int          cmp_count;
  int          i;
  int          waits;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  pbc_power_budget_regs pbc_power_budget_regs_i (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .hot_reset_n           (hot_reset_n),
    .hsel                  (hsel),
    .haddr                 (haddr),
    .htrans                (htrans),
    .hwrite                (hwrite),
    .hsize                 (hsize),
    .hwdata                (hwdata),
    .hready                (hready),
    .hrdata                (hrdata),
    .hreadyout             (hreadyout),
    .hresp                 (hresp),
    .system_allocated_flag (system_allocated_flag),
    .budget_value_unlock   (budget_value_unlock)
  );

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask : report_and_stop

  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      cmp_count++;
      if (seen !== exp)
      begin
        fails++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask : check

  // bounded wait: a hung slave ends the run instead of the simulator
  task wait_ready;
    int n;
    begin
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
        n++;
        if (n > 20)
        begin
          fails++;
          report_and_stop;
        end
        @(posedge hclk);
      end
      waits = n;
    end
  endtask : wait_ready

  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    begin
      hsel   <= 1'b1;
      haddr  <= {20'h0_0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_ready;
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready;
      rdat = hrdata;
    end
  endtask : xfer

  task wr(input logic [11:0] a, input logic [31:0] d);
    begin
      xfer(1'b1, a, d);
      check(32'(waits), 32'h0000_0000);
    end
  endtask : wr

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    begin
      xfer(1'b0, a, 32'h0000_0000);
      check(rdat, exp);
      check(32'(waits), 32'h0000_0001);
      check({31'h0000_0000, hresp}, 32'h0000_0000);
    end
  endtask : rd_chk

  function automatic logic [31:0] pat(input int k);
    return 32'hC0DE_0000 + 32'(k) * 32'h0000_0111;
  endfunction : pat

  function automatic logic [11:0] vaddr(input int k);
    return PBC_OFF_VAL_BASE + 12'(4 * k);
  endfunction : vaddr

  initial
  begin
    fails = 0;
    cmp_count = 0;
    hresetn <= 1'b0;
    hot_reset_n <= 1'b1;
    hsel <= 1'b0;
    haddr <= 32'h0000_0000;
    htrans <= 2'b00;
    hwrite <= 1'b0;
    hsize <= 3'b010;
    hwdata <= 32'h0000_0000;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({31'h0000_0000, system_allocated_flag}, 32'h0000_0000);
    check({31'h0000_0000, budget_value_unlock}, 32'h0000_0000);
    rd_chk(PBC_OFF_HDR, 32'h0000_0000);
    rd_chk(PBC_OFF_SEL, 32'h0000_0000);
    rd_chk(PBC_OFF_WINDOW, 32'h0000_0000);
    rd_chk(PBC_OFF_SYSALLOC, 32'h0000_0000);
    rd_chk(PBC_OFF_SW_CTRL, 32'h0000_0000);
    rd_chk(vaddr(0), 32'h0000_0000);
    $display("test reset_values done");
    wr(PBC_OFF_HDR, 32'h0001_0004);
    rd_chk(PBC_OFF_HDR, 32'h0000_0000);
    wr(PBC_OFF_SYSALLOC, 32'h0000_0001);
    rd_chk(PBC_OFF_SYSALLOC, 32'h0000_0000);
    wr(vaddr(0), pat(0));
    rd_chk(vaddr(0), 32'h0000_0000);
    $display("test locked_writes done");
    wr(PBC_OFF_SW_CTRL, 32'h0000_0001);
    @(posedge hclk);
    check({31'h0000_0000, budget_value_unlock}, 32'h0000_0000);
    wr(PBC_OFF_HDR, 32'h0001_0004);
    rd_chk(PBC_OFF_HDR, 32'h0001_0004);
    wr(PBC_OFF_SYSALLOC, 32'hFFFF_FFFF);
    rd_chk(PBC_OFF_SYSALLOC, 32'h0000_0001);
    check({31'h0000_0000, system_allocated_flag}, 32'h0000_0001);
    wr(vaddr(3), pat(3));
    rd_chk(vaddr(3), 32'h0000_0000);
    $display("test header_unlock done");
    // loader order: unlock values first, then preload all entries
    wr(PBC_OFF_SW_CTRL, 32'h0000_0003);
    @(posedge hclk);
    check({31'h0000_0000, budget_value_unlock}, 32'h0000_0001);
    for (i = 0; i < 8; i++)
      wr(vaddr(i), pat(i));
    for (i = 0; i < 8; i++)
      rd_chk(vaddr(i), pat(i));
    $display("test value_load done");
    for (i = 0; i < 8; i++)
    begin
      wr(PBC_OFF_SEL, 32'(i));
      rd_chk(PBC_OFF_WINDOW, pat(i));
    end
    wr(PBC_OFF_SEL, 32'h0000_0008);
    rd_chk(PBC_OFF_WINDOW, 32'h0000_0000);
    wr(PBC_OFF_SEL, 32'h0000_00FF);
    rd_chk(PBC_OFF_WINDOW, 32'h0000_0000);
    wr(PBC_OFF_SEL, 32'hFFFF_FF05);
    rd_chk(PBC_OFF_SEL, 32'h0000_0005);
    wr(PBC_OFF_WINDOW, 32'hFFFF_FFFF);
    rd_chk(PBC_OFF_WINDOW, pat(5));
    rd_chk(12'h0290, 32'h0000_0000);
    $display("test selector_window done");
    wr(PBC_OFF_SW_CTRL, 32'h0000_0001);
    wr(vaddr(2), 32'hDEAD_BEEF);
    rd_chk(vaddr(2), pat(2));
    $display("test value_relock done");
    hot_reset_n <= 1'b0;
    @(posedge hclk);
    hot_reset_n <= 1'b1;
    @(posedge hclk);
    check({31'h0000_0000, system_allocated_flag}, 32'h0000_0000);
    rd_chk(PBC_OFF_HDR, 32'h0000_0000);
    rd_chk(PBC_OFF_SEL, 32'h0000_0000);
    rd_chk(PBC_OFF_SW_CTRL, 32'h0000_0000);
    for (i = 0; i < 8; i++)
      rd_chk(vaddr(i), pat(i));
    rd_chk(PBC_OFF_WINDOW, pat(0));
    $display("test hot_reset done");
    report_and_stop;
  end
endmodule : pbc_power_budget_regs_bench
